// *** dv/bpsc_core_model.sv ***
// Core-side partner: software writes, interrupt starts and bus strobes
`timescale 1ns/1ps
`default_nettype none
module bpsc_core_model (
  input  wire logic  core_clk,
  input  wire logic  core_clk_run,
  output logic       sfr_wr_en,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic       irq_start,
  output logic       irq_start_ext_level,
  output logic       ext_level_irq_pending,
  output logic       core_ale,
  output logic       core_program_store_strobe_n_n
);
  initial begin
    {sfr_wr_en, irq_start, irq_start_ext_level, ext_level_irq_pending} = 4'h0;
    {sfr_addr, sfr_wdata} = 16'h0000;
    {core_ale, core_program_store_strobe_n_n} = 2'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Strobes toggle while clocked, so a stuck pass-through shows up
  always @(posedge core_clk) begin
    if (core_clk_run) begin
      core_ale    <= ~core_ale;
      core_program_store_strobe_n_n <= core_ale;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Released address and data show the inverse, never a stale byte
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge core_clk);
    sfr_wr_en <= 1'b1;
    sfr_addr  <= addr;
    sfr_wdata <= data;
    @(posedge core_clk);
    sfr_wr_en <= 1'b0;
    sfr_addr  <= ~addr;
    sfr_wdata <= ~data;
  endtask : sfr_write
  task automatic take_irq(input logic ext);
    @(posedge core_clk);
    irq_start           <= 1'b1;
    irq_start_ext_level <= ext;
    @(posedge core_clk);
    irq_start           <= 1'b0;
    irq_start_ext_level <= 1'b0;
  endtask : take_irq
  task automatic set_pending(input logic lvl);
    @(posedge core_clk);
    ext_level_irq_pending <= lvl;
  endtask : set_pending
  // Handler starts, then software drops the enable
  task automatic service_brownout;
    take_irq(1'b0);
    sfr_write(bpsc_pkg::AUX_IRQ_EN_ADDR, 8'h00);
  endtask : service_brownout
endmodule : bpsc_core_model
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the brown-out and power-save controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        core_clk, arst_n, droop_async, sfr_wr_en, irq_start, irq_start_ext_level;
  logic        ext_level_irq_pending, core_ale, core_program_store_strobe_n_n, brownout_active, brownout_irq_req;
  logic        cpu_reset, brownout_irq_enable, sleep_request_bit, powerdown_request_bit, pc_hold;
  logic        core_clk_run, ale_out, program_store_strobe_n, mode_idle, mode_powerdown;
  logic [7:0]  sfr_addr, sfr_wdata, power_control_reg, aux_irq_enable_reg;
  logic [15:0] brownout_irq_vector, cpu_reset_vector;
  int          fails;
  int          comparisons;
  int          n;

  bpsc_top dut (
    .core_clk(core_clk), .arst_n(arst_n), .droop_async(droop_async), .sfr_wr_en(sfr_wr_en),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .irq_start(irq_start), .core_ale(core_ale),
    .irq_start_ext_level(irq_start_ext_level), .ext_level_irq_pending(ext_level_irq_pending),
    .core_program_store_strobe_n_n(core_program_store_strobe_n_n), .brownout_active(brownout_active), .cpu_reset(cpu_reset),
    .brownout_irq_req(brownout_irq_req), .brownout_irq_vector(brownout_irq_vector),
    .cpu_reset_vector(cpu_reset_vector), .brownout_irq_enable(brownout_irq_enable),
    .sleep_request_bit(sleep_request_bit), .powerdown_request_bit(powerdown_request_bit),
    .power_control_reg(power_control_reg), .aux_irq_enable_reg(aux_irq_enable_reg),
    .pc_hold(pc_hold), .core_clk_run(core_clk_run), .ale_out(ale_out), .mode_idle(mode_idle),
    .program_store_strobe_n(program_store_strobe_n), .mode_powerdown(mode_powerdown));
  bpsc_core_model core (
    .core_clk(core_clk), .core_clk_run(core_clk_run), .sfr_wr_en(sfr_wr_en), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .irq_start(irq_start), .irq_start_ext_level(irq_start_ext_level),
    .ext_level_irq_pending(ext_level_irq_pending), .core_ale(core_ale), .core_program_store_strobe_n_n(core_program_store_strobe_n_n));

  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check16
  task automatic check1(input string what, input logic exp, input logic got);
    check16(what, {15'h0000, exp}, {15'h0000, got});
  endtask : check1
  task automatic give_verdict;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_state;
    @(posedge core_clk);
    #1;
    check16("control bytes", 16'h0000, {power_control_reg, aux_irq_enable_reg});
    check1("clock enable", 1'b1, core_clk_run & ~pc_hold & ~cpu_reset);
    check1("strobe pass-through", core_program_store_strobe_n_n, program_store_strobe_n);
  endtask : t_reset_state
  // Exactly four samples is the boundary: three must be ignored
  task automatic t_droop_filter;
    logic seen;
    seen = 1'b0;
    @(posedge core_clk);
    droop_async <= 1'b1;
    repeat (3) @(posedge core_clk);
    droop_async <= 1'b0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      seen |= brownout_active;
    end
    check1("short droop", 1'b0, seen);
    @(posedge core_clk);
    droop_async <= 1'b1;
    for (n = 1; n < 16; n++) begin
      @(posedge core_clk);
      if (n == 4) begin
        droop_async <= 1'b0;
      end
      #1;
      if (brownout_active === 1'b1) break;
    end
    check16("edges to brown-out", 16'h0006, 16'(n));
    @(posedge core_clk);
    #1;
    check1("default reset", 1'b1, cpu_reset);
    check1("no request when disabled", 1'b0, brownout_irq_req);
    check16("restart vector", bpsc_pkg::RESET_VECTOR, cpu_reset_vector);
    for (n = 0; n < 16 && cpu_reset !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
  endtask : t_droop_filter
  task automatic t_brownout_irq;
    core.sfr_write(8'hE9, 8'h08);
    #1;
    check1("enable via other address", 1'b0, brownout_irq_enable);
    core.sfr_write(bpsc_pkg::AUX_IRQ_EN_ADDR, 8'hFF);
    #1;
    check16("aux readback", 16'h0008, {8'h00, aux_irq_enable_reg});
    @(posedge core_clk);
    droop_async <= 1'b1;
    for (n = 0; n < 16 && brownout_irq_req !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    check16("interrupt vector", bpsc_pkg::BO_VECTOR, brownout_irq_vector);
    repeat (6) @(posedge core_clk);
    #1;
    check1("core keeps running", 1'b0, cpu_reset | ~brownout_irq_req);
    core.service_brownout();
    #1;
    check1("reset on enable clear", 1'b1, cpu_reset);
    @(posedge core_clk);
    droop_async <= 1'b0;
    for (n = 0; n < 16 && cpu_reset !== 1'b0; n++) begin
      @(posedge core_clk);
      #1;
    end
    check1("reset after recovery", 1'b0, cpu_reset);
  endtask : t_brownout_irq
  task automatic t_idle;
    core.sfr_write(bpsc_pkg::PWR_CTRL_ADDR, 8'h01);
    #1;
    check16("idle entry", 16'h0101, {power_control_reg, 7'h00, mode_idle});
    check16("request bits", 16'h0001, {14'h0000, powerdown_request_bit, sleep_request_bit});
    repeat (3) @(posedge core_clk);
    #1;
    check16("idle pins", 16'h001F, {11'h000, pc_hold, core_clk_run, ale_out, program_store_strobe_n,
                                     ~|aux_irq_enable_reg});
    core.take_irq(1'b0);
    #1;
    check16("idle exit", 16'h0000, {power_control_reg, 6'h00, mode_idle, pc_hold});
    check1("sleep bit cleared", 1'b0, sleep_request_bit);
    check1("ale pass-through", core_ale, ale_out);
  endtask : t_idle
  task automatic t_powerdown;
    core.sfr_write(bpsc_pkg::PWR_CTRL_ADDR, 8'h02);
    #1;
    check16("power-down entry", 16'h0201, {power_control_reg, 7'h00, mode_powerdown});
    check16("request bits", 16'h0002, {14'h0000, powerdown_request_bit, sleep_request_bit});
    check16("power-down pins", 16'h0004, {13'h0000, pc_hold, core_clk_run, ale_out | program_store_strobe_n});
    core.take_irq(1'b0);
    #1;
    check1("plain interrupt ignored", 1'b1, mode_powerdown);
    check1("power-down bit kept", 1'b1, powerdown_request_bit);
    core.set_pending(1'b1);
    #1;
    check1("clock for level wake", 1'b1, core_clk_run);
    core.take_irq(1'b1);
    #1;
    check16("power-down exit", 16'h0000, {power_control_reg, 7'h00, mode_powerdown});
    check1("power-down bit cleared", 1'b0, powerdown_request_bit);
    core.set_pending(1'b0);
  endtask : t_powerdown
  task automatic t_priority_reset;
    core.sfr_write(bpsc_pkg::AUX_IRQ_EN_ADDR, 8'h08);
    core.sfr_write(bpsc_pkg::PWR_CTRL_ADDR, 8'h03);
    #1;
    check16("both bits", 16'h0302, {power_control_reg, 6'h00, mode_powerdown, mode_idle});
    check16("both request bits", 16'h0003, {14'h0000, powerdown_request_bit, sleep_request_bit});
    @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    #1;
    check16("reset ends power-down", 16'h0001, {power_control_reg, aux_irq_enable_reg} | 16'(core_clk_run));
    @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    #1;
    check16("state after reset", 16'h0000, {power_control_reg, 6'h00, mode_powerdown, mode_idle});
  endtask : t_priority_reset
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk    = 1'b0;
    arst_n      = 1'b0;
    droop_async = 1'b0;
    fails       = 0;
    comparisons = 0;
    repeat (8) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset_state();
    t_droop_filter();
    t_brownout_irq();
    t_idle();
    t_powerdown();
    t_priority_reset();
    give_verdict();
  end
  // Whole run is under a hundred cycles; this is over thirty times that
  initial begin
    repeat (3000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// *** hdl/bpsc_droop_qual.sv ***
// Droop comparator synchroniser and qualification counter
`timescale 1ns/1ps
`default_nettype none
module bpsc_droop_qual #(
  parameter int QUAL_CYCLES = bpsc_pkg::QUAL_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic droop_async,
  output logic      droop_active
);

  localparam int CW = $clog2(QUAL_CYCLES + 1);
  localparam logic [CW-1:0] QUAL_LIMIT = CW'(QUAL_CYCLES);

  // Fewer cycles than the documented periods would let short droops through
  if (QUAL_CYCLES < bpsc_pkg::QUAL_PERIODS || QUAL_CYCLES > 255) begin : g_bad_qual
    $error("bpsc_droop_qual: QUAL_CYCLES out of range");
  end

  typedef struct packed {
    logic          sync_meta;
    logic          sync_stable;
    logic [CW-1:0] count;
    logic          active;
  } bpsc_qual_type;

  bpsc_qual_type r;
  bpsc_qual_type next_r;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r             = r;
    next_r.sync_meta   = droop_async;
    next_r.sync_stable = r.sync_meta;
    // Any gap in the droop restarts the count, so glitches never qualify
    if (!r.sync_stable) begin
      next_r.count = '0;
    end else if (r.count != QUAL_LIMIT) begin
      next_r.count = CW'(r.count + 1'b1);
    end
    next_r.active = r.sync_stable && (next_r.count == QUAL_LIMIT);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign droop_active = r.active;

  ////////////////////////////////////////////////////////////////////////////////
  AST_QUAL_MIN: assert property (@(posedge core_clk) disable iff (!arst_n)
    r.active |-> $past(r.sync_stable, 1) && $past(r.sync_stable, 2)
                 && $past(r.sync_stable, 3) && $past(r.sync_stable, 4))
    else $error("brown-out active before four droop periods");

  AST_QUAL_SYNC: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(r.sync_stable) |-> $past(droop_async, 2))
    else $error("droop reached counter without two stages");

  AST_QUAL_REACH: assert property (@(posedge core_clk) disable iff (!arst_n)
    (r.sync_stable && !r.active) [*4] |=> r.active)
    else $error("qualified droop did not raise brown-out");

endmodule : bpsc_droop_qual
`default_nettype wire

// *** hdl/bpsc_pkg.sv ***
// Constants and types of the brown-out and power-save controller
// Functional notes
// - A droop must last four consecutive clock periods before brown-out becomes active.
// - Qualified brown-out with interrupt enabled requests interrupt; processor keeps running.
// - By default, with enable still at reset value, brown-out resets the processor.
// - Brown-out interrupt enable is bit 3 of auxiliary enable register E8H.
// - With enable set, brown-out interrupt vectors to code address 004BH.
// - Clearing the enable while brown-out stays active resets the device.
// - With enable clear, brown-out resets processor to restart at 0000H.
// - Writing 01H to power control sets the sleep bit and enters idle.
// - Idle keeps clock and interrupts, holds program counter, drives both strobes high.
// - Any enabled interrupt ends idle and clears sleep bit; hardware reset also ends it.
// - Writing 02H to power control sets the power-down bit and enters power-down.
// - Power-down stops the core clock, keeps contents, drives both strobes low; here the clock runs while ext_level_irq_pending is set.
// - Only level-sensitive external interrupt or hardware reset ends power-down, clearing its bit; here a brown-out reset also ends it.
// - Hardware reset ending a low-power mode restarts like power-on reset.
package bpsc_pkg;

  localparam logic [7:0]  AUX_IRQ_EN_ADDR   = 8'hE8;
  localparam logic [7:0]  PWR_CTRL_ADDR     = 8'hA7;
  localparam int          BO_IRQ_EN_POS     = 3;
  localparam int          SLEEP_POS         = 0;
  localparam int          PDOWN_POS         = 1;
  localparam logic [15:0] BO_VECTOR         = 16'h004B;
  localparam logic [15:0] RESET_VECTOR      = 16'h0000;
  localparam int          CLK_PERIOD_PS     = 25000;
  localparam int          QUAL_PERIODS      = 4;
  localparam int          OSC_PERIOD_PS     = 25000;
  localparam int          QUAL_CYCLES       = (QUAL_PERIODS * OSC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic        RST_BO_IRQ_EN     = 1'b0;
  localparam logic        RST_SLEEP         = 1'b0;
  localparam logic        RST_PDOWN         = 1'b0;
  localparam logic        RST_CPU_RESET     = 1'b0;
  localparam logic [15:0] RST_IRQ_VECTOR    = 16'h0000;

  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_IDLE,
    MODE_PDOWN
  } bpsc_mode_type;

  typedef struct packed {
    logic          bo_irq_en;
    logic          sleep;
    logic          pdown;
    logic          irq_req;
    logic [15:0]   irq_vector;
    logic          cpu_reset;
    bpsc_mode_type mode;
  } bpsc_ctrl_type;

endpackage : bpsc_pkg

// *** hdl/bpsc_top.sv ***
// Brown-out response and idle / power-down sequencing
`timescale 1ns/1ps
`default_nettype none
module bpsc_top #(
  parameter int QUAL_CYCLES = bpsc_pkg::QUAL_CYCLES
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        droop_async,
  input  wire logic        sfr_wr_en,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        irq_start,
  input  wire logic        irq_start_ext_level,
  input  wire logic        ext_level_irq_pending,
  input  wire logic        core_ale,
  input  wire logic        core_program_store_strobe_n_n,
  output logic             brownout_active,
  output logic             brownout_irq_req,
  output logic [15:0]      brownout_irq_vector,
  output logic             cpu_reset,
  output logic [15:0]      cpu_reset_vector,
  output logic             brownout_irq_enable,
  output logic             sleep_request_bit,
  output logic             powerdown_request_bit,
  output logic [7:0]       power_control_reg,
  output logic [7:0]       aux_irq_enable_reg,
  output logic             pc_hold,
  output logic             core_clk_run,
  output logic             ale_out,
  output logic             program_store_strobe_n,
  output logic             mode_idle,
  output logic             mode_powerdown
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic sfr_hit(input logic wr, input logic [7:0] addr,
                                   input logic [7:0] target);
    sfr_hit = wr && (addr == target);
  endfunction : sfr_hit

  function automatic logic [7:0] place_bit(input logic v, input int pos);
    place_bit = 8'(v) << pos;
  endfunction : place_bit

  ////////////////////////////////////////////////////////////////////////////////
  // Droop qualification

  logic bo_active;

  bpsc_droop_qual #(
    .QUAL_CYCLES (QUAL_CYCLES)
  ) u_qual (
    .core_clk     (core_clk),
    .arst_n       (arst_n),
    .droop_async  (droop_async),
    .droop_active (bo_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Control state

  bpsc_pkg::bpsc_ctrl_type r;
  bpsc_pkg::bpsc_ctrl_type next_r;

  logic wr_aux;
  logic wr_pwr;
  logic bo_reset;
  logic wake_any;
  logic wake_pdown;

  // Writes are refused while the processor is held in reset
  assign wr_aux     = sfr_hit(sfr_wr_en, sfr_addr, bpsc_pkg::AUX_IRQ_EN_ADDR) && !r.cpu_reset;
  assign wr_pwr     = sfr_hit(sfr_wr_en, sfr_addr, bpsc_pkg::PWR_CTRL_ADDR) && !r.cpu_reset;
  assign wake_any   = irq_start;
  assign wake_pdown = irq_start && irq_start_ext_level;

  always_comb begin
    next_r = r;

    // Enable bit is software-owned; only a write or hardware reset clears it, a brown-out never does
    if (wr_aux) begin
      next_r.bo_irq_en = sfr_wdata[bpsc_pkg::BO_IRQ_EN_POS];
    end

    // Reset unless the enable, as just written, is set
    bo_reset = bo_active && !next_r.bo_irq_en;
    next_r.cpu_reset = bo_reset;

    // Interrupt is requested while the core keeps running
    next_r.irq_req = bo_active && next_r.bo_irq_en;
    if (next_r.irq_req) begin
      next_r.irq_vector = bpsc_pkg::BO_VECTOR;
    end

    // Sleep bit: a write that sets it beats a wake in the same cycle
    if (wr_pwr) begin
      next_r.sleep = sfr_wdata[bpsc_pkg::SLEEP_POS];
    end else if (wake_any) begin
      next_r.sleep = 1'b0;
    end

    // Power-down bit: a write wins over a wake; otherwise only a level external interrupt or a brown-out reset clears it
    if (wr_pwr) begin
      next_r.pdown = sfr_wdata[bpsc_pkg::PDOWN_POS];
    end else if (wake_pdown) begin
      next_r.pdown = 1'b0;
    end

    // A brown-out reset restarts the core out of any low-power mode
    if (bo_reset) begin
      next_r.sleep = bpsc_pkg::RST_SLEEP;
      next_r.pdown = bpsc_pkg::RST_PDOWN;
    end

    if (next_r.pdown) begin
      next_r.mode = bpsc_pkg::MODE_PDOWN;
    end else if (next_r.sleep) begin
      next_r.mode = bpsc_pkg::MODE_IDLE;
    end else begin
      next_r.mode = bpsc_pkg::MODE_RUN;
    end
  end

  // Hardware reset returns every bit to its power-on value
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      r.bo_irq_en  <= bpsc_pkg::RST_BO_IRQ_EN;
      r.sleep      <= bpsc_pkg::RST_SLEEP;
      r.pdown      <= bpsc_pkg::RST_PDOWN;
      r.irq_req    <= 1'b0;
      r.irq_vector <= bpsc_pkg::RST_IRQ_VECTOR;
      r.cpu_reset  <= bpsc_pkg::RST_CPU_RESET;
      r.mode       <= bpsc_pkg::MODE_RUN;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Mode outputs

  always_comb begin
    unique case (r.mode)
      bpsc_pkg::MODE_RUN: begin
        pc_hold                = 1'b0;
        core_clk_run           = 1'b1;
        ale_out                = core_ale;
        program_store_strobe_n = core_program_store_strobe_n_n;
      end
      bpsc_pkg::MODE_IDLE: begin
        pc_hold                = 1'b1;
        core_clk_run           = 1'b1;
        ale_out                = 1'b1;
        program_store_strobe_n = 1'b1;
      end
      bpsc_pkg::MODE_PDOWN: begin
        pc_hold                = 1'b1;
        // Clock restarts only so the core can take the level interrupt
        core_clk_run           = ext_level_irq_pending;
        ale_out                = 1'b0;
        program_store_strobe_n = 1'b0;
      end
      default: begin
        pc_hold                = 1'b0;
        core_clk_run           = 1'b1;
        ale_out                = core_ale;
        program_store_strobe_n = core_program_store_strobe_n_n;
      end
    endcase
  end

  assign brownout_active       = bo_active;
  assign brownout_irq_req      = r.irq_req;
  assign brownout_irq_vector   = r.irq_vector;
  assign cpu_reset             = r.cpu_reset;
  assign cpu_reset_vector      = bpsc_pkg::RESET_VECTOR;
  assign brownout_irq_enable   = r.bo_irq_en;
  assign sleep_request_bit     = r.sleep;
  assign powerdown_request_bit = r.pdown;
  assign power_control_reg     = place_bit(r.sleep, bpsc_pkg::SLEEP_POS)
                               | place_bit(r.pdown, bpsc_pkg::PDOWN_POS);
  assign aux_irq_enable_reg    = place_bit(r.bo_irq_en, bpsc_pkg::BO_IRQ_EN_POS);
  assign mode_idle             = (r.mode == bpsc_pkg::MODE_IDLE);
  assign mode_powerdown        = (r.mode == bpsc_pkg::MODE_PDOWN);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  AST_IRQ_VECTOR: assert property (@(posedge core_clk) disable iff (!arst_n)
    brownout_irq_req |-> $past(bo_active) && brownout_irq_vector == 16'h004B)
    else $error("brown-out interrupt without cause or with wrong vector");

  AST_IRQ_NO_HALT: assert property (@(posedge core_clk) disable iff (!arst_n)
    bo_active && brownout_irq_enable && !(sfr_wr_en && sfr_addr == 8'hE8)
    |=> brownout_irq_req && !cpu_reset)
    else $error("enabled brown-out halted the core");

  AST_DEFAULT_RESET: assert property (@(posedge core_clk) disable iff (!arst_n)
    bo_active && !brownout_irq_enable && !(sfr_wr_en && sfr_addr == 8'hE8)
    |=> cpu_reset && !brownout_irq_req)
    else $error("disabled brown-out did not reset the core");

  AST_ENABLE_BIT: assert property (@(posedge core_clk) disable iff (!arst_n)
    sfr_wr_en && sfr_addr == 8'hE8 && !cpu_reset
    |=> brownout_irq_enable == $past(sfr_wdata[3]) && aux_irq_enable_reg == {4'h0, $past(sfr_wdata[3]), 3'h0})
    else $error("enable bit not taken from bit 3 of E8H");

  AST_CLEAR_RESETS: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(brownout_irq_enable) && $past(bo_active) |-> cpu_reset)
    else $error("clearing enable during brown-out did not reset");

  AST_RESET_VECTOR: assert property (@(posedge core_clk) disable iff (!arst_n)
    cpu_reset |-> $past(bo_active) && cpu_reset_vector == 16'h0000 && !sleep_request_bit && !powerdown_request_bit)
    else $error("brown-out reset with wrong cause or vector");

  AST_IDLE_ENTER: assert property (@(posedge core_clk) disable iff (!arst_n)
    sfr_wr_en && sfr_addr == bpsc_pkg::PWR_CTRL_ADDR && sfr_wdata == 8'h01 && !cpu_reset && !bo_reset
    |=> mode_idle && power_control_reg == 8'h01)
    else $error("writing 01H did not enter idle");

  AST_IDLE_OUTPUTS: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_idle |-> pc_hold && core_clk_run && ale_out && program_store_strobe_n)
    else $error("idle outputs wrong");

  AST_IDLE_EXIT: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_idle && irq_start && !(sfr_wr_en && sfr_addr == bpsc_pkg::PWR_CTRL_ADDR)
    |=> !sleep_request_bit && !mode_idle)
    else $error("interrupt did not end idle");

  AST_PDOWN_ENTER: assert property (@(posedge core_clk) disable iff (!arst_n)
    sfr_wr_en && sfr_addr == bpsc_pkg::PWR_CTRL_ADDR && sfr_wdata[1] && !cpu_reset && !bo_reset
    |=> mode_powerdown && !mode_idle)
    else $error("power-down request did not enter power-down");

  AST_PDOWN_OUTPUTS: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_powerdown && !ext_level_irq_pending |-> pc_hold && !core_clk_run && !ale_out && !program_store_strobe_n)
    else $error("power-down outputs wrong");

  AST_PDOWN_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_powerdown && !(irq_start && irq_start_ext_level) && !bo_reset
    && !(sfr_wr_en && sfr_addr == bpsc_pkg::PWR_CTRL_ADDR)
    |=> mode_powerdown && powerdown_request_bit)
    else $error("power-down left without level external interrupt");

  AST_PDOWN_EXIT: assert property (@(posedge core_clk) disable iff (!arst_n)
    mode_powerdown && irq_start && irq_start_ext_level && !(sfr_wr_en && sfr_addr == bpsc_pkg::PWR_CTRL_ADDR)
    |=> !powerdown_request_bit && mode_powerdown == 1'b0)
    else $error("level external interrupt did not end power-down");

endmodule : bpsc_top
`default_nettype wire
